// ==== lro_pkg.sv ====
package lro_pkg;

  // One decoded bit slot as it travels through the pipe and the FIFO
  typedef struct packed {
    logic pos;
    logic neg;
    logic code_violation_flag;
  } lro_rail_t;

  // Sampled pin group, all crossing into the system clock together
  typedef struct packed {
    logic line_clk;
    logic line_pos;
    logic line_neg;
    logic ref_clk;
    logic host_mode;
    logic dec_bypass;
    logic e3_mode;
    logic alt_clk_sel;
    logic fall_edge_sel;
    logic test_tristate_n;
  } lro_pins_t;

  typedef enum logic [1:0] {
    LRO_LK_COUNT = 2'b01,
    LRO_LK_JUDGE = 2'b10
  } lro_lock_state_t;

  localparam int LRO_RAIL_W = $bits(lro_rail_t);
  localparam int LRO_PINS_W = $bits(lro_pins_t);
  localparam int LRO_FIFO_DEPTH = 8;
  localparam int LRO_PIPE_DEPTH = 4;
  localparam int LRO_B3ZS_B_POS = 1;
  localparam int LRO_HDB3_B_POS = 2;
  localparam lro_rail_t LRO_RAIL_IDLE = '0;
  localparam lro_pins_t LRO_PINS_RST = '0;
  localparam logic LRO_POL_RST = 1'b0;
  localparam logic LRO_LOCK_LOST_RST = 1'b0;

  // Lock window in recovered clock bits and tolerance in parts per mille
  localparam int LRO_CNT_W = 16;
  localparam int LRO_LOCK_WIN = 2000;
  localparam int LRO_LOCK_TOL_PPM = 5;
  localparam logic [LRO_CNT_W-1:0] LRO_LOCK_WIN_C =
    LRO_CNT_W'(LRO_LOCK_WIN);
  localparam logic [LRO_CNT_W-1:0] LRO_LOCK_TOL_C =
    LRO_CNT_W'(LRO_LOCK_WIN * LRO_LOCK_TOL_PPM / 1000);

endpackage : lro_pkg

// ==== lro_sync.sv ====
`timescale 1ns/1ps
module lro_sync
  import lro_pkg::*;
#(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] d_i,
  output logic [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] sync_q;

  // First stage is read by the second stage only
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d_i;
      sync_q <= meta_q;
    end
  end

  assign q_o = sync_q;

endmodule : lro_sync

// ==== lro_fifo.sv ====
`timescale 1ns/1ps
module lro_fifo
  import lro_pkg::*;
#(
  parameter int WIDTH = LRO_RAIL_W,
  parameter int DEPTH = LRO_FIFO_DEPTH
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW:0] wr_ptr_q;
  logic [AW:0] rd_ptr_q;

  wire full = (wr_ptr_q[AW] != rd_ptr_q[AW]) &&
              (wr_ptr_q[AW-1:0] == rd_ptr_q[AW-1:0]);
  wire empty = (wr_ptr_q == rd_ptr_q);
  wire push = in_valid_i && !full;
  wire pop = out_ready_i && !empty;

  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = mem_q[rd_ptr_q[AW-1:0]];

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem_q[wr_ptr_q[AW-1:0]] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
    end else begin
      if (push) begin
        wr_ptr_q <= wr_ptr_q + (AW+1)'(1);
      end
      if (pop) begin
        rd_ptr_q <= rd_ptr_q + (AW+1)'(1);
      end
    end
  end

endmodule : lro_fifo

// ==== lro_rx_out.sv ====
// Function
// - Host mode: shared output carries code violation flag by default.
// - Host mode: selection puts second recovered clock on shared output.
// - Hardware mode: shared output always carries the recovered clock.
// - Primary clock output always carries the recovered line clock.
// - Pulse outputs change on recovered clock rising edge by default.
// - Host mode, alternate clock selected: falling edge update allowed.
// - Host mode: software may pick falling edge update for data.
// - Negative output goes high for each received negative pulse.
// - Positive output goes high for each received positive pulse.
// - Decoder enabled: substitution codes removed, original zeros shown.
// - Test input low floats every output.
// - Test input idles high, so outputs stay driven normally.
// - Violation flag pulses high one bit period per code violation.
// - Bypass input high skips decoding, low enables decoding.
// - Flag lock lost when recovered and reference differ over 0.5%.
`timescale 1ns/1ps
module lro_rx_out
  import lro_pkg::*;
(
  // Clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  // Line side, from clock recovery
  input wire logic LINE_CLK_I,
  input wire logic LINE_POS_I,
  input wire logic LINE_NEG_I,
  input wire logic REFERENCE_CLOCK_IN_I,
  // Mode and configuration straps
  input wire logic HOST_MODE_I,
  input wire logic DECODER_BYPASS_IN_I,
  input wire logic E3_MODE_I,
  input wire logic ALT_CLK_SEL_I,
  input wire logic FALL_EDGE_SEL_I,
  input wire logic BOARD_TEST_TRISTATE_N_I,
  // Terminal side
  output logic RECOVERED_CLOCK_OUT_O,
  output logic RECOVERED_CLOCK_ALT_OUT_O,
  output logic RX_POSITIVE_PULSE_OUT_O,
  output logic RX_NEGATIVE_PULSE_OUT_O,
  output logic LOCK_LOST_FLAG_O,
  output logic OUT_EN_O
);

  // Mark test on a single rail slot: true when exactly one pulse is present
  function automatic logic is_pulse(input lro_rail_t r);
    return r.pos ^ r.neg;
  endfunction : is_pulse

  // Edge of a sampled clock against its value one cycle earlier
  function automatic logic rise_of(input logic cur, input logic prev);
    return cur && !prev;
  endfunction : rise_of

  function automatic logic fall_of(input logic cur, input logic prev);
    return !cur && prev;
  endfunction : fall_of

  lro_pins_t pins_raw;
  lro_pins_t pins_s;

  assign pins_raw = '{
    line_clk: LINE_CLK_I,
    line_pos: LINE_POS_I,
    line_neg: LINE_NEG_I,
    ref_clk: REFERENCE_CLOCK_IN_I,
    host_mode: HOST_MODE_I,
    dec_bypass: DECODER_BYPASS_IN_I,
    e3_mode: E3_MODE_I,
    alt_clk_sel: ALT_CLK_SEL_I,
    fall_edge_sel: FALL_EDGE_SEL_I,
    test_tristate_n: BOARD_TEST_TRISTATE_N_I
  };

  // Data and clock share one synchroniser so their skew stays equal
  lro_sync #(
    .WIDTH(LRO_PINS_W)
  ) u_sync (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .d_i(pins_raw),
    .q_o(pins_s)
  );

  // Edge detection on the synchronised clocks
  logic line_clk_prev_q;
  logic ref_clk_prev_q;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      line_clk_prev_q <= 1'b0;
      ref_clk_prev_q <= 1'b0;
    end else begin
      line_clk_prev_q <= pins_s.line_clk;
      ref_clk_prev_q <= pins_s.ref_clk;
    end
  end

  wire line_rise = rise_of(pins_s.line_clk, line_clk_prev_q);
  wire line_fall = fall_of(pins_s.line_clk, line_clk_prev_q);
  wire ref_rise = rise_of(pins_s.ref_clk, ref_clk_prev_q);

  wire dec_en = !pins_s.dec_bypass;
  wire host = pins_s.host_mode;

  // Decode pipe: slot 0 is the newest bit, the last slot goes to the FIFO
  lro_rail_t pipe_q [LRO_PIPE_DEPTH];
  lro_rail_t pipe_d [LRO_PIPE_DEPTH];
  logic last_pol_q;
  logic seen_q;
  logic fifo_in_ready;

  lro_rail_t new_bit;
  assign new_bit = '{pos: pins_s.line_pos, neg: pins_s.line_neg, code_violation_flag: 1'b0};

  wire new_pulse = is_pulse(new_bit);
  wire new_both = pins_s.line_pos && pins_s.line_neg;
  wire bip_viol = new_pulse && seen_q && (new_bit.pos == last_pol_q);

  // Mark present in each pipe slot
  logic [LRO_PIPE_DEPTH-1:0] slot_mark;

  genvar m;
  generate
    for (m = 0; m < LRO_PIPE_DEPTH; m++) begin : g_mark
      assign slot_mark[m] = is_pulse(pipe_q[m]);
    end
  endgenerate

  // Zero gap before V: one slot for B3ZS, two for HDB3
  wire gap_zero = pins_s.e3_mode ?
    !(slot_mark[0] || slot_mark[1]) :
    !slot_mark[0];
  wire valid_sub = bip_viol && gap_zero;

  // B slot of a B0V or B00V pattern, same polarity as V
  lro_rail_t b_slot;
  assign b_slot = pins_s.e3_mode ? pipe_q[LRO_HDB3_B_POS]
                                 : pipe_q[LRO_B3ZS_B_POS];
  wire b_hit = is_pulse(b_slot) && (b_slot.pos == new_bit.pos);

  wire strip = dec_en && valid_sub;
  wire code_viol = new_bit.pos && new_bit.neg ||
                   (bip_viol && !strip);

  // Pipe only moves when the FIFO can take the leaving bit
  wire advance = line_rise && fifo_in_ready;

  always_comb begin
    pipe_d[0] = strip ? LRO_RAIL_IDLE : new_bit;
    pipe_d[0].code_violation_flag = code_viol;
    for (int k = 1; k < LRO_PIPE_DEPTH; k++) begin
      pipe_d[k] = pipe_q[k-1];
    end
    if (strip && b_hit) begin
      if (pins_s.e3_mode) begin
        pipe_d[LRO_HDB3_B_POS+1].pos = 1'b0;
        pipe_d[LRO_HDB3_B_POS+1].neg = 1'b0;
      end else begin
        pipe_d[LRO_B3ZS_B_POS+1].pos = 1'b0;
        pipe_d[LRO_B3ZS_B_POS+1].neg = 1'b0;
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < LRO_PIPE_DEPTH; g++) begin : g_pipe
      always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
        if (RST_I) begin
          pipe_q[g] <= LRO_RAIL_IDLE;
        end else if (advance) begin
          pipe_q[g] <= pipe_d[g];
        end
      end
    end
  endgenerate

  // Raw line polarity of the last mark, for violation checking
  logic last_pol_d;
  logic seen_d;
  // Double marks are no polarity reference, so they are skipped
  wire mark_taken = advance && new_pulse && !new_both;
  assign last_pol_d = mark_taken ? new_bit.pos : last_pol_q;
  assign seen_d = mark_taken || seen_q;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      last_pol_q <= LRO_POL_RST;
      seen_q <= 1'b0;
    end else begin
      last_pol_q <= last_pol_d;
      seen_q <= seen_d;
    end
  end

  // Elastic buffer between decode and the terminal side
  logic fifo_out_valid;
  lro_rail_t fifo_out_data;

  wire fall_en = host && pins_s.fall_edge_sel;
  wire upd = fall_en ? line_fall : line_rise;

  lro_fifo #(
    .WIDTH(LRO_RAIL_W),
    .DEPTH(LRO_FIFO_DEPTH)
  ) u_fifo (
    .clk_i(CLK_SYS_I),
    .rst_i(RST_I),
    .in_valid_i(line_rise),
    .in_ready_o(fifo_in_ready),
    .in_data_i(pipe_q[LRO_PIPE_DEPTH-1]),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(upd),
    .out_data_o(fifo_out_data)
  );

  // Output stage, one word per bit period on the chosen edge
  logic out_clk_q;
  logic out_clk_d;
  lro_rail_t out_q;
  lro_rail_t out_d;
  lro_rail_t pop_word;

  // Empty FIFO shows a zero slot rather than stale data
  assign pop_word = fifo_out_valid ? fifo_out_data : LRO_RAIL_IDLE;
  assign out_clk_d = pins_s.line_clk;
  assign out_d = upd ? pop_word : out_q;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      out_clk_q <= 1'b0;
      out_q <= LRO_RAIL_IDLE;
    end else begin
      out_clk_q <= out_clk_d;
      out_q <= out_d;
    end
  end

  wire alt_is_clk = !host || pins_s.alt_clk_sel;

  assign RECOVERED_CLOCK_OUT_O = out_clk_q;
  assign RECOVERED_CLOCK_ALT_OUT_O = alt_is_clk ? out_clk_q : out_q.code_violation_flag;
  assign RX_POSITIVE_PULSE_OUT_O = out_q.pos;
  assign RX_NEGATIVE_PULSE_OUT_O = out_q.neg;

  lro_lock_state_t lk_state_q;
  lro_lock_state_t lk_state_d;
  logic [LRO_CNT_W-1:0] line_cnt_q;
  logic [LRO_CNT_W-1:0] line_cnt_d;
  logic [LRO_CNT_W-1:0] ref_cnt_q;
  logic [LRO_CNT_W-1:0] ref_cnt_d;
  logic lock_lost_q;
  logic lock_lost_d;

  // Window counted in line bits, so the limit follows any line rate
  wire win_done = line_cnt_q == LRO_LOCK_WIN_C;
  // Saturate so a far-off reference cannot wrap back into tolerance
  wire ref_sat = &ref_cnt_q;
  wire ref_above = ref_cnt_q > LRO_LOCK_WIN_C;
  wire [LRO_CNT_W-1:0] diff_above = ref_cnt_q - LRO_LOCK_WIN_C;
  wire [LRO_CNT_W-1:0] diff_below = LRO_LOCK_WIN_C - ref_cnt_q;
  wire [LRO_CNT_W-1:0] diff = ref_above ? diff_above : diff_below;
  wire off_freq = diff > LRO_LOCK_TOL_C;

  always_comb begin
    lk_state_d = lk_state_q;
    line_cnt_d = line_cnt_q;
    ref_cnt_d = ref_cnt_q;
    lock_lost_d = lock_lost_q;
    case (lk_state_q)
      LRO_LK_COUNT: begin
        if (line_rise) begin
          line_cnt_d = line_cnt_q + LRO_CNT_W'(1);
        end
        if (ref_rise && !ref_sat) begin
          ref_cnt_d = ref_cnt_q + LRO_CNT_W'(1);
        end
        if (win_done) begin
          lk_state_d = LRO_LK_JUDGE;
        end
      end
      LRO_LK_JUDGE: begin
        lock_lost_d = off_freq;
        line_cnt_d = '0;
        ref_cnt_d = '0;
        lk_state_d = LRO_LK_COUNT;
      end
      default: begin
        lk_state_d = LRO_LK_COUNT;
      end
    endcase
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      lk_state_q <= LRO_LK_COUNT;
      line_cnt_q <= '0;
      ref_cnt_q <= '0;
      lock_lost_q <= LRO_LOCK_LOST_RST;
    end else begin
      lk_state_q <= lk_state_d;
      line_cnt_q <= line_cnt_d;
      ref_cnt_q <= ref_cnt_d;
      lock_lost_q <= lock_lost_d;
    end
  end

  assign LOCK_LOST_FLAG_O = lock_lost_q;

  // idle high drive
  // The pin's pull-up sits on the board; only the level is seen here
  assign OUT_EN_O = pins_s.test_tristate_n;

endmodule : lro_rx_out

// ==== lro_rx_out_chk.sv ====
`timescale 1ns/1ps
module lro_rx_out_chk (
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic LINE_CLK_I,
  input wire logic HOST_MODE_I,
  input wire logic ALT_CLK_SEL_I,
  input wire logic FALL_EDGE_SEL_I,
  input wire logic BOARD_TEST_TRISTATE_N_I,
  input wire logic RECOVERED_CLOCK_OUT_O,
  input wire logic RECOVERED_CLOCK_ALT_OUT_O,
  input wire logic RX_POSITIVE_PULSE_OUT_O,
  input wire logic RX_NEGATIVE_PULSE_OUT_O,
  input wire logic OUT_EN_O
);
  default clocking @(posedge CLK_SYS_I); endclocking
  default disable iff (RST_I);
  // Modes are compared against four cycles back to skip the sync lag
  property p_clk_follow;
    $rose(LINE_CLK_I) |-> ##[1:6] $rose(RECOVERED_CLOCK_OUT_O);
  endproperty
  a_clk_follow: assert property (p_clk_follow)
    else $error("recovered clock did not follow line clock");
  property p_hw_alt;
    !HOST_MODE_I && !$past(HOST_MODE_I, 4)
      |-> RECOVERED_CLOCK_ALT_OUT_O == RECOVERED_CLOCK_OUT_O;
  endproperty
  a_hw_alt: assert property (p_hw_alt)
    else $error("alt output not the clock in hardware mode");
  property p_host_clk;
    HOST_MODE_I && $past(HOST_MODE_I, 4) && ALT_CLK_SEL_I
      && $past(ALT_CLK_SEL_I, 4)
      |-> RECOVERED_CLOCK_ALT_OUT_O == RECOVERED_CLOCK_OUT_O;
  endproperty
  a_host_clk: assert property (p_host_clk)
    else $error("alt output not the clock when selected");
  property p_lcv_edge;
    HOST_MODE_I && $past(HOST_MODE_I, 4) && !ALT_CLK_SEL_I
      && !$past(ALT_CLK_SEL_I, 4) && !FALL_EDGE_SEL_I
      && !$past(FALL_EDGE_SEL_I, 4) && $changed(RECOVERED_CLOCK_ALT_OUT_O)
      |-> $rose(RECOVERED_CLOCK_OUT_O);
  endproperty
  a_lcv_edge: assert property (p_lcv_edge)
    else $error("violation flag moved off the active edge");
  property p_rise_data;
    ((!HOST_MODE_I && !$past(HOST_MODE_I, 4))
      || (!FALL_EDGE_SEL_I && !$past(FALL_EDGE_SEL_I, 4)))
      && ($changed(RX_POSITIVE_PULSE_OUT_O)
      || $changed(RX_NEGATIVE_PULSE_OUT_O))
      |-> $rose(RECOVERED_CLOCK_OUT_O);
  endproperty
  a_rise_data: assert property (p_rise_data)
    else $error("data changed off the rising edge");
  property p_fall_data;
    HOST_MODE_I && $past(HOST_MODE_I, 4) && FALL_EDGE_SEL_I
      && $past(FALL_EDGE_SEL_I, 4) && ($changed(RX_POSITIVE_PULSE_OUT_O)
      || $changed(RX_NEGATIVE_PULSE_OUT_O))
      |-> $fell(RECOVERED_CLOCK_OUT_O);
  endproperty
  a_fall_data: assert property (p_fall_data)
    else $error("data changed off the falling edge");
  property p_pos_len;
    $rose(RX_POSITIVE_PULSE_OUT_O) |=> RX_POSITIVE_PULSE_OUT_O [*5];
  endproperty
  a_pos_len: assert property (p_pos_len)
    else $error("positive mark shorter than a bit");
  property p_neg_len;
    $rose(RX_NEGATIVE_PULSE_OUT_O) |=> RX_NEGATIVE_PULSE_OUT_O [*5];
  endproperty
  a_neg_len: assert property (p_neg_len)
    else $error("negative mark shorter than a bit");
  property p_float;
    !BOARD_TEST_TRISTATE_N_I [*4] |-> !OUT_EN_O;
  endproperty
  a_float: assert property (p_float)
    else $error("outputs still driven in test float");
  property p_drive;
    BOARD_TEST_TRISTATE_N_I [*5] |-> OUT_EN_O;
  endproperty
  a_drive: assert property (p_drive)
    else $error("outputs not driven with test pin high");
endmodule : lro_rx_out_chk
bind lro_rx_out lro_rx_out_chk u_chk (.*);

// ==== lro_framer_model.sv ====
`timescale 1ns/1ps
module lro_framer_model (
  input wire logic clk_i,
  input wire logic clr_i,
  input wire logic fall_i,
  input wire logic rclk_i,
  input wire logic pos_i,
  input wire logic neg_i,
  input wire logic lcv_i,
  input wire logic oe_i,
  output logic [7:0] npos_o,
  output logic [7:0] nneg_o,
  output logic [7:0] nlcv_o
);
  logic rclk_q;
  logic smp;
  // Sample mid-bit, on the edge opposite the active one
  assign smp = oe_i && (fall_i ? (rclk_i && !rclk_q) : (!rclk_i && rclk_q));
  always @(posedge clk_i) begin
    rclk_q <= rclk_i;
    if (clr_i) begin
      npos_o <= 8'h00;
      nneg_o <= 8'h00;
      nlcv_o <= 8'h00;
    end else if (smp) begin
      npos_o <= npos_o + 8'(pos_i);
      nneg_o <= nneg_o + 8'(neg_i);
      nlcv_o <= nlcv_o + 8'(lcv_i);
    end
  end
endmodule : lro_framer_model

// ==== lro_rx_out_bench.sv ====
`timescale 1ns/1ps
module lro_rx_out_bench;
  logic clk = 0, rst = 1, lclk = 0, lpos = 0, lneg = 0, refclk = 0;
  logic host = 0, byp = 1, e3 = 0, alt = 0, fall = 0, tst_n = 1, clr = 0;
  logic rclk, ralt, rx_positive_pulse_out, rx_negative_pulse_out, lock_lost_flag, oen;
  logic [7:0] npos, nneg, nlcv;
  logic [2:0] lcnt = 3'h0;
  logic [1:0] lq[$];
  int rhalf = 4, rcnt = 0, n_mismatch = 0, n_checks = 0;
  always #10 clk = ~clk;
  // Line bits change on the falling line clock, mid-way between samples
  always @(posedge clk) begin
    lcnt <= lcnt + 3'h1;
    if (lcnt == 3'h3) lclk <= 1'b1;
    if (lcnt == 3'h7) begin
      lclk <= 1'b0;
      {lpos, lneg} <= lq.size() ? lq.pop_front() : 2'h0;
    end
  end
  always @(posedge clk) begin
    if (rcnt >= rhalf - 1) begin
      rcnt <= 0;
      refclk <= ~refclk;
    end else rcnt <= rcnt + 1;
  end
  lro_rx_out uut (.CLK_SYS_I(clk), .RST_I(rst), .LINE_CLK_I(lclk),
    .LINE_POS_I(lpos), .LINE_NEG_I(lneg), .REFERENCE_CLOCK_IN_I(refclk),
    .HOST_MODE_I(host), .DECODER_BYPASS_IN_I(byp), .E3_MODE_I(e3),
    .ALT_CLK_SEL_I(alt), .FALL_EDGE_SEL_I(fall),
    .BOARD_TEST_TRISTATE_N_I(tst_n), .RECOVERED_CLOCK_OUT_O(rclk),
    .RECOVERED_CLOCK_ALT_OUT_O(ralt), .RX_POSITIVE_PULSE_OUT_O(rx_positive_pulse_out),
    .RX_NEGATIVE_PULSE_OUT_O(rx_negative_pulse_out), .LOCK_LOST_FLAG_O(lock_lost_flag), .OUT_EN_O(oen));
  lro_framer_model u_frm (.clk_i(clk), .clr_i(clr), .fall_i(fall && host),
    .rclk_i(rclk), .pos_i(rx_positive_pulse_out), .neg_i(rx_negative_pulse_out), .lcv_i(ralt), .oe_i(oen),
    .npos_o(npos), .nneg_o(nneg), .nlcv_o(nlcv));
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Fixed flush covers pipe, FIFO and output latency of a few bits
  task run(input string s);
    repeat (8) @(posedge clk);
    clr <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    foreach (s[i]) lq.push_back(s[i] == "P" ? 2'h2 : s[i] == "N" ? 2'h1 : 2'h0);
    repeat (320) @(posedge clk);
  endtask : run
  task t_ami;
    fall <= 1'b1;
    run("PNPNPNP");
    chk(npos, 8'h04);
    chk(nneg, 8'h03);
    $display("test ami done");
  endtask : t_ami
  task t_b3zs;
    byp <= 1'b0;
    run("NP00PN0N");
    chk(npos, 8'h01);
    chk(nneg, 8'h01);
    $display("test b3zs done");
  endtask : t_b3zs
  task t_hdb3;
    e3 <= 1'b1;
    run("P000PN00N");
    chk(npos, 8'h01);
    chk(nneg, 8'h00);
    $display("test hdb3 done");
  endtask : t_hdb3
  task t_lcv;
    host <= 1'b1;
    fall <= 1'b0;
    byp <= 1'b1;
    e3 <= 1'b0;
    run("PN00NP0P");
    chk(npos, 8'h03);
    chk(nlcv, 8'h02);
    $display("test violation done");
  endtask : t_lcv
  task t_fall;
    alt <= 1'b1;
    fall <= 1'b1;
    run("NPNP");
    chk(npos, 8'h02);
    chk(nneg, 8'h02);
    $display("test falling edge done");
  endtask : t_fall
  task t_float;
    tst_n <= 1'b0;
    repeat (5) @(posedge clk);
    chk(8'(oen), 8'h00);
    tst_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk(8'(oen), 8'h01);
    $display("test float done");
  endtask : t_float
  task wait_lol(input logic v);
    int k;
    for (k = 0; k < 40000 && lock_lost_flag !== v; k++) @(posedge clk);
    chk(8'(lock_lost_flag), 8'(v));
    if (lock_lost_flag !== v) finish_test();
  endtask : wait_lol
  task t_lock;
    rhalf <= 5;
    wait_lol(1'b1);
    rhalf <= 4;
    wait_lol(1'b0);
    $display("test lock done");
  endtask : t_lock
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_ami();
    t_b3zs();
    t_hdb3();
    t_lcv();
    t_fall();
    t_float();
    t_lock();
    finish_test();
  end
endmodule : lro_rx_out_bench
